/* ccfc_pkg.sv */
// Purpose: constants and carrier types for the protocol field counter core
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: preload figures are field lengths minus one, counted down to zero
// Behaviour
// [R1] Bus monitoring mode drives recessive on the transmit line.
// [R2] Destuffer takes receive pin, or looped-back stuffed data under secondary sampling.
// [R3] Bus monitoring mode feeds destuffer with stuffed data OR receive pin.
// [R4] Regular field transitions happen only in the process stage.
// [R5] Error frame request moves to error flag one clock after process, from anywhere.
// [R6] Field counter preloads in process stage and decrements by one per bit.
// [R7] Counter flags value one and value zero; field ends at zero.
// [R8] No counting in single-bit fields or unbounded fields like bus idle.
// [R9] Preloads: base identifier 10, extension 17, length code 3.
// [R10] Preloads: end of frame 7, interframe 2, suspend 7, integration 10; the core has no suspend state and PL_SUSP is never loaded.
// [R11] Data field preload follows payload length.
// [R12] CRC preload 14, 16 or 20 by CRC length.
// [R13] Stuff count with parity preloads 3.
// [R14] Error and overload flags preload 5.
// [R15] Error and overload delimiters preload 7.
// [R16] Reintegration loads 11 repeatedly, 128 times in total.
// [R17] Auxiliary up-counter counts from zero, once per bit, only in data field.
// [R18] Byte done at aux mod 8 zero, word done at aux mod 32 zero.
// [R19] Payload word index confined to 4 through 19.
// [R20] Word index is aux divided by 32 plus 4.
// [R21] Arbitration loss in process stage captures counter and sub-field type.
// [R22] Captured loss position readable through the capture register.
// [R23] Dominant bit during reintegration reloads 10 and restarts the run.
// [R24] Preload beats decrement in the same process cycle.
package ccfc_pkg;
   localparam int CNT_W = 9;
   localparam logic [8:0] PL_BASE_ID = 9'h00_0A;
   localparam logic [8:0] PL_EXT_ID = 9'h01_1;
   localparam logic [8:0] PL_DLC = 9'h00_3;
   localparam logic [8:0] PL_EOF = 9'h00_7;
   localparam logic [8:0] PL_IFS = 9'h00_2;
   localparam logic [8:0] PL_SUSP = 9'h00_7;
   localparam logic [8:0] PL_INTEG = 9'h00_A;
   localparam logic [8:0] PL_CRC15 = 9'h00_E;
   localparam logic [8:0] PL_CRC17 = 9'h01_0;
   localparam logic [8:0] PL_CRC21 = 9'h01_4;
   localparam logic [8:0] PL_STC = 9'h00_3;
   localparam logic [8:0] PL_FLAG = 9'h00_5;
   localparam logic [8:0] PL_DELIM = 9'h00_7;
   localparam logic [8:0] PL_REINT = 9'h00_B;
   localparam logic [8:0] PL_REINT_DOM = 9'h00_A;
   localparam logic [7:0] REINT_LAST = 8'h80;
   localparam logic [4:0] WORD_BASE = 5'h04;
   localparam logic [4:0] WORD_LAST = 5'h13;
   localparam logic [8:0] ONE = 9'h00_1;

   typedef enum logic [12:0] {
      CCFC_IDLE = 13'h0001, CCFC_BASE = 13'h0002, CCFC_IDE = 13'h0004,
      CCFC_EXT = 13'h0008, CCFC_DLC = 13'h0010, CCFC_DATA = 13'h0020,
      CCFC_STC = 13'h0040, CCFC_CRC = 13'h0080, CCFC_EOF = 13'h0100,
      CCFC_IFS = 13'h0200, CCFC_FLAG = 13'h0400, CCFC_DELIM = 13'h0800,
      CCFC_INTEG = 13'h1000
   } ccfc_state_t;

   typedef enum logic [1:0] {CCFC_CRC_15 = 2'h0, CCFC_CRC_17 = 2'h1,
      CCFC_CRC_21 = 2'h2} ccfc_crc_t;

   // Sub-field code kept in the capture register
   typedef enum logic [2:0] {CCFC_AL_BASE = 3'h1, CCFC_AL_SRR = 3'h2, CCFC_AL_IDE = 3'h3,
      CCFC_AL_EXT = 3'h4, CCFC_AL_RTR = 3'h5} ccfc_alfield_t;

   typedef struct packed {
      logic [8:0] position;
      ccfc_alfield_t field;
   } ccfc_alc_t;

   typedef struct packed {
      logic cnt_one;
      logic cnt_zero;
      logic byte_done;
      logic word_done;
      logic reint_done;
   } ccfc_flags_t;
endpackage

/* ccfc_core.sv */
// Purpose: CAN core datapath muxes, field-timed protocol state and field counter
// Assumes: sample pulse marks the sample point; process stage is the following clock
// Notes: frame content, stuffing, CRC and fault confinement live outside this block
`timescale 1ns/100ps
module ccfc_core #(
   parameter int DATA_BITS_MAX = 512
) (
   input wire logic ref_clk_in, // 200 MHz clock
   input wire logic reset_in, // Synchronous reset, active high
   input wire logic can_rx_in, // Receive pin from transceiver
   output logic can_tx_out, // Transmit pin to transceiver
   input wire logic stuffed_tx_in, // Bit-stuffed transmit data
   output logic destuff_in_out, // Data feeding the destuffer
   input wire logic bus_mon_in, // Bus monitoring mode
   input wire logic ssp_used_in, // Secondary sample point in use
   input wire logic sample_in, // Sample point pulse
   input wire logic err_req_in, // Error frame request pulse
   input wire logic ovr_req_in, // Overload request, taken in process stage
   input wire logic sof_in, // Start of frame seen while idle
   input wire logic ide_in, // Identifier extension flag of current frame
   input wire logic fd_in, // FD frame with stuff count field
   input wire logic reint_in, // Reintegration after bus-off
   input wire logic enable_in, // Core enabled, integration starts
   input wire logic [8:0] data_bits_in, // Payload length in bits
   input wire ccfc_pkg::ccfc_crc_t crc_len_in, // CRC sequence length in use
   input wire logic arb_lost_in, // Arbitration loss, pulse in process stage
   input wire ccfc_pkg::ccfc_alfield_t al_field_in, // Arbitration sub-field being sent
   output ccfc_pkg::ccfc_state_t state_out, // Protocol field state
   output logic [8:0] field_cnt_out, // Field counter
   output ccfc_pkg::ccfc_flags_t flags_out, // Counter indications
   output logic [4:0] word_idx_out, // Payload word index in transmit buffer
   output logic word_idx_vld_out, // Word index inside payload window
   output ccfc_pkg::ccfc_alc_t arb_loss_capture_reg_out // Arbitration loss capture
);
   // Word window 4..19 only covers a 512 bit payload, so refuse anything else
   if (DATA_BITS_MAX != 512) begin : g_bad_max
      $error("DATA_BITS_MAX must be 512 to fit a 64 byte payload");
   end

   logic rx_s1_ff, rx_s2_ff;
   logic proc_ff, err_ff;
   logic [8:0] cnt_ff, nxt_cnt;
   logic [8:0] aux_ff, nxt_aux;
   logic [7:0] reint_ff, nxt_reint;
   ccfc_pkg::ccfc_state_t state_ff, nxt_state;
   ccfc_pkg::ccfc_alc_t alc_ff;
   logic bus_bit;
   logic cnt_zero, cnt_one, load;
   logic [8:0] load_val;
   logic [8:0] data_pl, crc_pl;
   logic counting, in_data;

   // Pin passes two flip-flops before use
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
      end else begin
         rx_s1_ff <= can_rx_in;
         rx_s2_ff <= rx_s1_ff;
      end
   end

   assign can_tx_out = bus_mon_in ? 1'b1 : stuffed_tx_in; // [R1]
   assign destuff_in_out = bus_mon_in ? (stuffed_tx_in | rx_s2_ff) : // [R3]
      (ssp_used_in ? stuffed_tx_in : rx_s2_ff); // [R2]
   assign bus_bit = destuff_in_out;

   assign cnt_zero = (cnt_ff == '0); // [R7]
   assign cnt_one = (cnt_ff == ccfc_pkg::ONE); // [R7]
   assign data_pl = data_bits_in - ccfc_pkg::ONE; // [R11]
   assign crc_pl = (crc_len_in == ccfc_pkg::CCFC_CRC_21) ? ccfc_pkg::PL_CRC21 : // [R12]
      (crc_len_in == ccfc_pkg::CCFC_CRC_17) ? ccfc_pkg::PL_CRC17 : ccfc_pkg::PL_CRC15;
   assign in_data = (state_ff == ccfc_pkg::CCFC_DATA);
   // Single-bit and unbounded fields hold the counter still
   assign counting = (state_ff != ccfc_pkg::CCFC_IDLE) && (state_ff != ccfc_pkg::CCFC_IDE); // [R8]

   // Next state and preload, evaluated only in the process stage
   always_comb begin
      nxt_state = state_ff;
      load = 1'b0;
      load_val = cnt_ff;
      nxt_reint = reint_ff;
      unique case (state_ff)
         ccfc_pkg::CCFC_IDLE: begin
            if (sof_in) begin
               nxt_state = ccfc_pkg::CCFC_BASE;
               load = 1'b1;
               load_val = ccfc_pkg::PL_BASE_ID; // [R9]
            end
         end
         ccfc_pkg::CCFC_BASE: begin
            if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_IDE;
            end
         end
         ccfc_pkg::CCFC_IDE: begin
            load = 1'b1;
            nxt_state = ide_in ? ccfc_pkg::CCFC_EXT : ccfc_pkg::CCFC_DLC;
            load_val = ide_in ? ccfc_pkg::PL_EXT_ID : ccfc_pkg::PL_DLC; // [R9]
         end
         ccfc_pkg::CCFC_EXT: begin
            if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_DLC;
               load = 1'b1;
               load_val = ccfc_pkg::PL_DLC; // [R9]
            end
         end
         ccfc_pkg::CCFC_DLC: begin
            if (cnt_zero) begin
               load = 1'b1;
               if (data_bits_in != '0) begin
                  nxt_state = ccfc_pkg::CCFC_DATA;
                  load_val = data_pl; // [R11]
               end else if (fd_in) begin
                  nxt_state = ccfc_pkg::CCFC_STC;
                  load_val = ccfc_pkg::PL_STC; // [R13]
               end else begin
                  nxt_state = ccfc_pkg::CCFC_CRC;
                  load_val = crc_pl; // [R12]
               end
            end
         end
         ccfc_pkg::CCFC_DATA: begin
            if (cnt_zero) begin
               load = 1'b1;
               nxt_state = fd_in ? ccfc_pkg::CCFC_STC : ccfc_pkg::CCFC_CRC;
               load_val = fd_in ? ccfc_pkg::PL_STC : crc_pl; // [R13] [R12]
            end
         end
         ccfc_pkg::CCFC_STC: begin
            if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_CRC;
               load = 1'b1;
               load_val = crc_pl; // [R12]
            end
         end
         ccfc_pkg::CCFC_CRC: begin
            if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_EOF;
               load = 1'b1;
               load_val = ccfc_pkg::PL_EOF; // [R10]
            end
         end
         ccfc_pkg::CCFC_EOF, ccfc_pkg::CCFC_DELIM: begin
            if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_IFS;
               load = 1'b1;
               load_val = ccfc_pkg::PL_IFS; // [R10]
            end
         end
         ccfc_pkg::CCFC_IFS: begin
            if (ovr_req_in) begin
               nxt_state = ccfc_pkg::CCFC_FLAG;
               load = 1'b1;
               load_val = ccfc_pkg::PL_FLAG; // [R14]
            end else if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_IDLE;
            end
         end
         ccfc_pkg::CCFC_FLAG: begin
            if (cnt_zero) begin
               nxt_state = ccfc_pkg::CCFC_DELIM;
               load = 1'b1;
               load_val = ccfc_pkg::PL_DELIM; // [R15]
            end
         end
         ccfc_pkg::CCFC_INTEG: begin
            if (reint_in && !bus_bit) begin
               load = 1'b1;
               load_val = ccfc_pkg::PL_REINT_DOM; // [R23]
            end else if (!bus_bit) begin
               load = 1'b1;
               load_val = ccfc_pkg::PL_INTEG; // [R10]
            end else if (cnt_zero) begin
               if (reint_in && reint_ff != ccfc_pkg::REINT_LAST) begin
                  nxt_reint = reint_ff + 8'h01;
                  load = 1'b1;
                  load_val = ccfc_pkg::PL_REINT; // [R16]
               end else begin
                  nxt_state = ccfc_pkg::CCFC_IDLE;
                  nxt_reint = '0;
               end
            end
         end
      endcase
   end

   // Preload wins over decrement at a field boundary
   assign nxt_cnt = load ? load_val : // [R24] [R6]
      ((counting && !cnt_zero) ? cnt_ff - ccfc_pkg::ONE : cnt_ff); // [R6]
   assign nxt_aux = in_data ? aux_ff + ccfc_pkg::ONE : '0; // [R17]

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         proc_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         proc_ff <= sample_in;
         err_ff <= proc_ff && err_req_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !enable_in) begin
         state_ff <= ccfc_pkg::CCFC_INTEG;
         cnt_ff <= ccfc_pkg::PL_INTEG;
         aux_ff <= '0;
         reint_ff <= '0;
      end else if (err_ff) begin
         state_ff <= ccfc_pkg::CCFC_FLAG; // [R5]
         cnt_ff <= ccfc_pkg::PL_FLAG; // [R14]
         aux_ff <= '0;
      end else if (proc_ff) begin
         state_ff <= nxt_state; // [R4]
         cnt_ff <= nxt_cnt;
         aux_ff <= nxt_aux;
         reint_ff <= nxt_reint;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         alc_ff <= '0;
      end else if (proc_ff && arb_lost_in) begin
         alc_ff <= '{position: cnt_ff, field: al_field_in}; // [R21]
      end
   end

   assign word_idx_out = {1'b0, aux_ff[8:5]} + ccfc_pkg::WORD_BASE; // [R20]
   assign word_idx_vld_out = in_data && (word_idx_out >= ccfc_pkg::WORD_BASE) &&
      (word_idx_out <= ccfc_pkg::WORD_LAST); // [R19]
   assign state_out = state_ff;
   assign field_cnt_out = cnt_ff;
   assign arb_loss_capture_reg_out = alc_ff; // [R22]
   assign flags_out = '{cnt_one: cnt_one, cnt_zero: cnt_zero, // [R7]
      byte_done: in_data && (aux_ff[2:0] == 3'h0), // [R18]
      word_done: in_data && (aux_ff[4:0] == 5'h00), // [R18]
      reint_done: (reint_ff == ccfc_pkg::REINT_LAST)}; // [R16]
endmodule

/* ccfc_core_sva.sv */
// Purpose: port-level checker for the protocol field counter core
// Assumes: process stage is the clock after sample_in, error flag one clock later
// Notes: watches only top-level ports
`timescale 1ns/100ps
module ccfc_core_sva (
   input wire logic ref_clk_in, // Clock
   input wire logic reset_in, // Reset
   input wire logic enable_in, // Core enable, low forces integration
   input wire logic can_tx_out, // Transmit pin
   input wire logic stuffed_tx_in, // Stuffed data
   input wire logic destuff_in_out, // Destuffer feed
   input wire logic bus_mon_in, // Monitoring mode
   input wire logic ssp_used_in, // Secondary sampling
   input wire logic sample_in, // Sample pulse
   input wire logic err_req_in, // Error request
   input wire logic arb_lost_in, // Arbitration loss
   input wire ccfc_pkg::ccfc_alfield_t al_field_in, // Sub-field
   input wire ccfc_pkg::ccfc_state_t state_out, // State
   input wire logic [8:0] field_cnt_out, // Counter
   input wire ccfc_pkg::ccfc_flags_t flags_out, // Flags
   input wire logic [4:0] word_idx_out, // Word index
   input wire logic word_idx_vld_out, // Index valid
   input wire ccfc_pkg::ccfc_alc_t arb_loss_capture_reg_out // Capture
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   AST_TX_MON: assert property (bus_mon_in |-> can_tx_out) else $error("tx not recessive");
   AST_TX_PASS: assert property (!bus_mon_in |-> can_tx_out == stuffed_tx_in)
      else $error("tx not stuffed data");
   AST_SSP: assert property (!bus_mon_in && ssp_used_in |-> destuff_in_out == stuffed_tx_in)
      else $error("no loopback");
   AST_MON_OR: assert property (bus_mon_in && stuffed_tx_in |-> destuff_in_out)
      else $error("monitor or lost");
   AST_STATE_TIME: assert property ($changed(state_out) |-> $past(sample_in, 2) ||
      $past(err_req_in, 2) || $past(reset_in) || !$past(enable_in))
      else $error("state moved off process");
   AST_ERR_FLAG: assert property (sample_in ##1 err_req_in |-> ##2
      state_out == ccfc_pkg::CCFC_FLAG && field_cnt_out == 9'h005) else $error("no error flag");
   AST_DEC: assert property (sample_in ##1 !err_req_in ##1 ($stable(state_out) &&
      !(state_out inside {ccfc_pkg::CCFC_IDLE, ccfc_pkg::CCFC_IDE, ccfc_pkg::CCFC_INTEG}))
      |-> field_cnt_out == $past(field_cnt_out) - 9'h001) else $error("no decrement");
   AST_FLAGS: assert property (flags_out.cnt_zero == (field_cnt_out == 9'h000) &&
      flags_out.cnt_one == (field_cnt_out == 9'h001)) else $error("count flags wrong");
   AST_BASE_LOAD: assert property ($changed(state_out) && state_out == ccfc_pkg::CCFC_BASE
      |-> field_cnt_out == 9'h00A) else $error("base preload wrong");
   AST_CAPTURE: assert property (sample_in ##1 arb_lost_in |=>
      arb_loss_capture_reg_out == {$past(field_cnt_out), $past(al_field_in)})
      else $error("capture wrong");
   AST_WORD: assert property (word_idx_vld_out |-> word_idx_out inside {[4:19]})
      else $error("word index out of window");
   CV_ERR: cover property (sample_in ##1 err_req_in);
   CV_ARB: cover property (sample_in ##1 arb_lost_in);
   CV_WORD: cover property (word_idx_vld_out && word_idx_out == 5'h05);
   CV_REINT: cover property (flags_out.reint_done);
endmodule
bind ccfc_core ccfc_core_sva chk (.ref_clk_in, .reset_in, .enable_in, .can_tx_out, .stuffed_tx_in,
   .destuff_in_out, .bus_mon_in, .ssp_used_in, .sample_in, .err_req_in, .arb_lost_in,
   .al_field_in, .state_out, .field_cnt_out, .flags_out, .word_idx_out, .word_idx_vld_out,
   .arb_loss_capture_reg_out);

/* ccfc_xcvr.sv */
// Purpose: transceiver and bus model, wired-AND of own transmit and another node
// Assumes: dominant is 0, bus pulled recessive
// Notes: LOOP_NS sets the loop delay, raise it for a slow transceiver
`timescale 1ns/100ps
module ccfc_xcvr #(
   parameter int LOOP_NS = 2
) (
   input wire logic tx_in, // Own transmit pin
   input wire logic node_b_in, // Other node, 0 is dominant
   output logic rx_out // Bus level back to the core
);
   // Any dominant driver wins the bus
   assign #(LOOP_NS) rx_out = tx_in & node_b_in;
endmodule

/* test_ccfc_core.sv */
// Purpose: self-checking bench for the protocol field counter core
// Assumes: all inputs change by NBA at rising edges
// Notes: counter model follows whichever field state the core reports
`timescale 1ns/100ps
module test_ccfc_core;
   logic ref_clk_in = 0, reset_in = 1, stuffed_tx_in = 1, bus_mon_in = 0, ssp_used_in = 0;
   logic sample_in = 0, err_req_in = 0, ovr_req_in = 0, sof_in = 0, ide_in = 0, fd_in = 0;
   logic reint_in = 0, enable_in = 0, arb_lost_in = 0, node_b = 1;
   logic [8:0] data_bits_in = 9'h040;
   ccfc_pkg::ccfc_crc_t crc_len_in = ccfc_pkg::CCFC_CRC_15;
   ccfc_pkg::ccfc_alfield_t al_field_in = ccfc_pkg::CCFC_AL_EXT;
   logic can_rx_in, can_tx_out, destuff_in_out, word_idx_vld_out;
   ccfc_pkg::ccfc_state_t state_out, prev_st;
   logic [8:0] field_cnt_out, exp_cnt;
   ccfc_pkg::ccfc_flags_t flags_out;
   logic [4:0] word_idx_out;
   ccfc_pkg::ccfc_alc_t cap_val;
   int fails = 0, tests_run = 0, k = 0;
   ccfc_core uut (.ref_clk_in, .reset_in, .can_rx_in, .can_tx_out, .stuffed_tx_in,
      .destuff_in_out, .bus_mon_in, .ssp_used_in, .sample_in, .err_req_in, .ovr_req_in,
      .sof_in, .ide_in, .fd_in, .reint_in, .enable_in, .data_bits_in, .crc_len_in,
      .arb_lost_in, .al_field_in, .state_out, .field_cnt_out, .flags_out, .word_idx_out,
      .word_idx_vld_out, .arb_loss_capture_reg_out(cap_val));
   ccfc_xcvr #(.LOOP_NS(2)) bus (.tx_in(can_tx_out), .node_b_in(node_b), .rx_out(can_rx_in));
   task check(input logic [12:0] seen, input logic [12:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function logic [8:0] preload(input ccfc_pkg::ccfc_state_t st);
      case (st)
         ccfc_pkg::CCFC_BASE, ccfc_pkg::CCFC_INTEG: return 9'h00A;
         ccfc_pkg::CCFC_EXT: return 9'h011;
         ccfc_pkg::CCFC_DLC, ccfc_pkg::CCFC_STC: return 9'h003;
         ccfc_pkg::CCFC_DATA: return data_bits_in - 9'h001;
         ccfc_pkg::CCFC_CRC: return crc_len_in == ccfc_pkg::CCFC_CRC_15 ? 9'h00E :
            crc_len_in == ccfc_pkg::CCFC_CRC_17 ? 9'h010 : 9'h014;
         ccfc_pkg::CCFC_EOF, ccfc_pkg::CCFC_DELIM: return 9'h007;
         ccfc_pkg::CCFC_IFS: return 9'h002;
         ccfc_pkg::CCFC_FLAG: return 9'h005;
         default: return exp_cnt;
      endcase
   endfunction
   // One bit: sample pulse, process cycle with requests, then judge the counter
   task step(input logic sof, input logic err, input logic arb);
      logic [8:0] was;
      logic counted;
      was = exp_cnt;
      prev_st = state_out;
      counted = !(prev_st inside {ccfc_pkg::CCFC_IDLE, ccfc_pkg::CCFC_IDE});
      @(posedge ref_clk_in) sample_in <= 1;
      @(posedge ref_clk_in) begin
         sample_in <= 0;
         sof_in <= sof;
         err_req_in <= err;
         arb_lost_in <= arb;
      end
      @(posedge ref_clk_in) begin
         sof_in <= 0;
         err_req_in <= 0;
         arb_lost_in <= 0;
      end
      if (err) @(posedge ref_clk_in);
      #1;
      if (state_out !== prev_st) exp_cnt = preload(state_out);
      else if (prev_st === ccfc_pkg::CCFC_INTEG && !node_b) exp_cnt = 9'h00A;
      else if (prev_st === ccfc_pkg::CCFC_INTEG && reint_in && was === 9'h000) begin
         exp_cnt = 9'h00B;
      end else if (counted) exp_cnt = was - 9'h001;
      check(field_cnt_out, exp_cnt);
      check(flags_out.cnt_zero, exp_cnt === 9'h000);
      check(flags_out.cnt_one, exp_cnt === 9'h001);
      // A reintegration reload to 11 starts a new recessive run in place
      if (counted && was === 9'h000) check(state_out !== prev_st || exp_cnt === 9'h00B, 1);
      if (state_out === ccfc_pkg::CCFC_DATA) begin
         check(word_idx_out, 13'(k / 32 + 4));
         check(word_idx_vld_out, 1);
         check(flags_out.byte_done, k % 8 == 0);
         check(flags_out.word_done, k % 32 == 0);
         k++;
      end else k = 0;
      if (arb) check(cap_val, {was, al_field_in});
   endtask
   task mux_test;
      logic [3:0] v;
      logic rx;
      for (int i = 0; i < 16; i++) begin
         v = 4'(i);
         @(posedge ref_clk_in) {node_b, stuffed_tx_in, ssp_used_in, bus_mon_in} <= v;
         repeat (4) @(posedge ref_clk_in);
         #1;
         rx = (v[0] | v[2]) & v[3];
         check(can_tx_out, v[0] | v[2]);
         check(destuff_in_out, v[0] ? (v[2] | rx) : v[1] ? v[2] : rx);
      end
      @(posedge ref_clk_in) {node_b, stuffed_tx_in, ssp_used_in, bus_mon_in} <= 4'hC;
      repeat (4) @(posedge ref_clk_in);
   endtask
   task integ_test;
      @(posedge ref_clk_in) enable_in <= 1;
      step(0, 0, 0);
      step(0, 0, 0);
      // Dominant bit mid-run restarts the recessive count
      @(posedge ref_clk_in) node_b <= 0;
      repeat (3) @(posedge ref_clk_in);
      step(0, 0, 0);
      @(posedge ref_clk_in) node_b <= 1;
      repeat (3) @(posedge ref_clk_in);
      for (int i = 0; i < 11; i++) step(0, 0, 0);
      check(state_out, ccfc_pkg::CCFC_IDLE);
   endtask
   task frame_test(input logic ide, input logic fd, input ccfc_pkg::ccfc_crc_t crc);
      @(posedge ref_clk_in) begin
         ide_in <= ide;
         fd_in <= fd;
         crc_len_in <= crc;
      end
      step(1, 0, 0);
      check(state_out, ccfc_pkg::CCFC_BASE);
      for (int i = 0; i < 400 && state_out !== ccfc_pkg::CCFC_IDLE; i++) step(0, 0, 0);
      check(state_out, ccfc_pkg::CCFC_IDLE);
   endtask
   task err_arb_test;
      step(1, 0, 0);
      step(0, 0, 0);
      step(0, 0, 1);
      step(0, 1, 0);
      check(state_out, ccfc_pkg::CCFC_FLAG);
      for (int i = 0; i < 100 && state_out !== ccfc_pkg::CCFC_IFS; i++) step(0, 0, 0);
      // Overload request is only looked at during interframe space
      @(posedge ref_clk_in) ovr_req_in <= 1;
      step(0, 0, 0);
      @(posedge ref_clk_in) ovr_req_in <= 0;
      check(state_out, ccfc_pkg::CCFC_FLAG);
      for (int i = 0; i < 100 && state_out !== ccfc_pkg::CCFC_IDLE; i++) step(0, 0, 0);
      check(state_out, ccfc_pkg::CCFC_IDLE);
   endtask
   task reint_test;
      int n;
      int loads;
      n = 0;
      loads = 0;
      @(posedge ref_clk_in) enable_in <= 0;
      @(posedge ref_clk_in) begin
         enable_in <= 1;
         reint_in <= 1;
      end
      #1;
      exp_cnt = 9'h00A;
      check(state_out, ccfc_pkg::CCFC_INTEG);
      step(0, 0, 0);
      @(posedge ref_clk_in) node_b <= 0;
      repeat (3) @(posedge ref_clk_in);
      step(0, 0, 0);
      @(posedge ref_clk_in) node_b <= 1;
      repeat (3) @(posedge ref_clk_in);
      while (state_out === ccfc_pkg::CCFC_INTEG && n < 2000) begin
         step(0, 0, 0);
         n++;
         if (field_cnt_out === 9'h00B) loads++;
         if (state_out === ccfc_pkg::CCFC_INTEG) check(flags_out.reint_done, loads == 128);
      end
      check(state_out, ccfc_pkg::CCFC_IDLE);
      // First run of 11 bits from preload 10, then 128 runs of 12 bits from 11
      check(13'(n), 13'(11 + 128 * 12));
      @(posedge ref_clk_in) reint_in <= 0;
   endtask
   initial forever #2.5 ref_clk_in = ~ref_clk_in;
   initial begin
      repeat (3) @(posedge ref_clk_in);
      reset_in <= 0;
      @(posedge ref_clk_in);
      #1;
      exp_cnt = 9'h00A;
      check(state_out, ccfc_pkg::CCFC_INTEG);
      check(field_cnt_out, exp_cnt);
      check(cap_val, 0);
      mux_test();
      integ_test();
      frame_test(0, 0, ccfc_pkg::CCFC_CRC_15);
      frame_test(1, 1, ccfc_pkg::CCFC_CRC_17);
      frame_test(0, 1, ccfc_pkg::CCFC_CRC_21);
      @(posedge ref_clk_in) data_bits_in <= 9'h000;
      frame_test(0, 0, ccfc_pkg::CCFC_CRC_15);
      err_arb_test();
      reint_test();
      summarize();
   end
   // Longest path is about 6100 cycles, so this only trips on a hang
   initial begin
      repeat (40000) @(posedge ref_clk_in);
      fails++;
      summarize();
   end
endmodule
